// ### verilog/coc_pkg.sv
/*
 Constants, register map and field layout of the crystal oscillator control block.
 Assumes a 32-bit AHB-Lite register bus and one system clock hclk.
*/
package coc_pkg;
	// Clock
	localparam int CLK_PERIOD_NS = 100;
	// Byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PAUSE = 8'h08;
	localparam logic [7:0] OFS_STARTUP = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	// Control fields
	localparam int CTRL_EN_LSB = 12;
	localparam int CTRL_EN_MSB = 23;
	localparam int CTRL_FR_MSB = 11;
	localparam logic [11:0] EN_CODE_DISABLE = 12'hD1E;
	localparam logic [11:0] EN_CODE_ENABLE = 12'hFAB;
	localparam logic [11:0] FREQ_RANGE_RESET = 12'hAA0;
	// Status fields
	localparam int ST_STABLE_BIT = 31;
	localparam int ST_BAD_BIT = 24;
	localparam int ST_ENABLED_BIT = 12;
	// Pause codes
	localparam logic [31:0] PAUSE_CODE_SLEEP = 32'h636F6D61;
	localparam logic [31:0] PAUSE_CODE_WAKE = 32'h77616B65;
	// Startup fields
	localparam int SU_DELAY_MSB = 13;
	localparam int SU_X4_BIT = 20;
	localparam logic [13:0] SU_DELAY_RESET = 14'h00C4;
	localparam int SU_UNIT_LOG2 = 8;
	localparam int TIMER_W = 24;
	// Down counter
	localparam int CNT_W = 8;
	localparam logic [7:0] CNT_RESET = 8'h00;
	// Interrupt bits and bus word size
	localparam int IRQ_N = 3;
	localparam int IRQ_STABLE = 0;
	localparam int IRQ_BADWR = 1;
	localparam int IRQ_CNTDONE = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : coc_pkg

// ### verilog/coc_crystal_osc_control.sv
/*
 Register and timing logic of an on-chip crystal oscillator: protected enable, fixed range,
 pause and wake, startup timer, crystal down counter and interrupt status, as an AHB-Lite slave.
 Assumes the analog oscillator pulses xtal_clk_pin (slower than hclk/2) and raises wake_pin to wake.
*/
// Implementation choice: register access over AHB-Lite.
// Functional notes
// - Control bits 23:12: code 0xD1E turns oscillator off, 0xFAB turns it on.
// - Any other enable code written leaves the oscillator enabled.
// - After reset the enable field holds the disable code.
// - Range field bits 11:0 reads 0xAA0 and ignores writes.
// - Status bit 31 read-only, set only while running and stable.
// - Status bit 24 flags invalid enable, range or pause writes; reset zero, writing one clears.
// - Status bit 12 read-only shows oscillator enabled; resets to zero.
// - Status bits 1:0 report range and always read zero.
// - Pause code 0x636F6D61 stops oscillator; 0x77616B65 selects wake.
// - Pause register resets to wake; undefined values also select wake.
// - Startup delay bits 13:0 in units of 256 crystal periods, reset 0x00C4.
// - Startup bit 20 multiplies the delay by four; resets to zero.
// - Counter bits 7:0 decrement per crystal cycle, hold at zero, reset zero.
// - Writing the counter loads the value and starts counting down.
// - Stable flag sets when the startup timer expires.
// - Wake while paused restarts oscillator; stable only after the startup delay again.
`timescale 1ns/1ns
`default_nettype none
module coc_crystal_osc_control
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Oscillator side
	input wire logic xtal_clk_pin,
	input wire logic wake_pin,
	output logic osc_enable,
	output logic osc_stable,
	// Interrupt
	output logic irq
);
	import coc_pkg::*;

	typedef struct packed {
		logic xtal_s1;
		logic xtal_s2;
		logic xtal_s3;
		logic wake_s1;
		logic wake_s2;
		logic dp_sel;
		logic dp_write;
		logic [7:2] dp_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic [11:0] enable_code;
		logic paused;
		logic [13:0] delay;
		logic times_four;
		logic [TIMER_W-1:0] timer;
		logic stable;
		logic bad_write;
		logic [CNT_W-1:0] down_count;
		logic [IRQ_N-1:0] irq_status;
		logic [IRQ_N-1:0] irq_mask;
		logic osc_enable;
		logic irq;
	} coc_state_t;

	coc_state_t st;
	coc_state_t next_st;
	logic tick;
	logic enabled;
	logic running;
	logic take;
	logic wr_ctrl;
	logic wr_status;
	logic wr_pause;
	logic wr_startup;
	logic wr_count;
	logic wr_irq_status;
	logic wr_irq_mask;
	logic bad_ctrl;
	logic bad_pause;
	logic [TIMER_W-1:0] target;
	logic [TIMER_W:0] timer_inc;
	logic [31:0] rd_word;
	logic [IRQ_N-1:0] irq_events;
	logic next_running;

	assign tick = st.xtal_s2 & ~st.xtal_s3;
	assign enabled = st.enable_code != EN_CODE_DISABLE;
	assign running = enabled & ~st.paused;
	assign take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
	assign wr_ctrl = st.dp_sel & st.dp_write & (st.dp_addr == OFS_CTRL[7:2]);
	assign wr_status = st.dp_sel & st.dp_write & (st.dp_addr == OFS_STATUS[7:2]);
	assign wr_pause = st.dp_sel & st.dp_write & (st.dp_addr == OFS_PAUSE[7:2]);
	assign wr_startup = st.dp_sel & st.dp_write & (st.dp_addr == OFS_STARTUP[7:2]);
	assign wr_count = st.dp_sel & st.dp_write & (st.dp_addr == OFS_COUNT[7:2]);
	assign wr_irq_status = st.dp_sel & st.dp_write & (st.dp_addr == OFS_IRQ_STATUS[7:2]);
	assign wr_irq_mask = st.dp_sel & st.dp_write & (st.dp_addr == OFS_IRQ_MASK[7:2]);
	assign bad_ctrl = wr_ctrl & (((hwdata[CTRL_EN_MSB:CTRL_EN_LSB] != EN_CODE_DISABLE)
		& (hwdata[CTRL_EN_MSB:CTRL_EN_LSB] != EN_CODE_ENABLE))
		| (hwdata[CTRL_FR_MSB:0] != FREQ_RANGE_RESET));
	assign bad_pause = wr_pause & (hwdata != PAUSE_CODE_SLEEP) & (hwdata != PAUSE_CODE_WAKE);
	// Delay in crystal periods: units of 256, optionally times four
	assign target = st.times_four ? {st.delay, 10'h000} : {2'h0, st.delay, 8'h00};
	assign timer_inc = {1'b0, st.timer} + {{TIMER_W{1'b0}}, 1'b1};

	always_comb
	begin
		rd_word = 32'h00000000;
		case (haddr[7:2])
			OFS_CTRL[7:2]: rd_word = {8'h00, st.enable_code, FREQ_RANGE_RESET};
			OFS_STATUS[7:2]:
			begin
				rd_word[ST_STABLE_BIT] = st.stable;
				rd_word[ST_BAD_BIT] = st.bad_write;
				rd_word[ST_ENABLED_BIT] = enabled;
				rd_word[1:0] = 2'h0;
			end
			OFS_PAUSE[7:2]: rd_word = st.paused ? PAUSE_CODE_SLEEP : PAUSE_CODE_WAKE;
			OFS_STARTUP[7:2]:
			begin
				rd_word[SU_DELAY_MSB:0] = st.delay;
				rd_word[SU_X4_BIT] = st.times_four;
			end
			OFS_COUNT[7:2]: rd_word[CNT_W-1:0] = st.down_count;
			OFS_IRQ_STATUS[7:2]: rd_word[IRQ_N-1:0] = st.irq_status;
			OFS_IRQ_MASK[7:2]: rd_word[IRQ_N-1:0] = st.irq_mask;
			default: rd_word = 32'h00000000;
		endcase
	end

	always_comb
	begin
		next_st = st;
		irq_events = 3'h0;
		// Synchronisers and edge detect
		next_st.xtal_s1 = xtal_clk_pin;
		next_st.xtal_s2 = st.xtal_s1;
		next_st.xtal_s3 = st.xtal_s2;
		next_st.wake_s1 = wake_pin;
		next_st.wake_s2 = st.wake_s1;
		// Bus: zero wait states, read data captured in the address phase
		next_st.hreadyout = 1'b1;
		next_st.hresp = 1'b0;
		next_st.dp_sel = take;
		next_st.dp_write = hwrite;
		next_st.dp_addr = haddr[7:2];
		if (take && !hwrite)
		begin
			next_st.hrdata = rd_word;
		end
		// Enable field
		if (wr_ctrl)
		begin
			next_st.enable_code = hwdata[CTRL_EN_MSB:CTRL_EN_LSB];
		end
		// Wake pin restarts a paused oscillator
		if (st.paused && st.wake_s2)
		begin
			next_st.paused = 1'b0;
		end
		if (wr_pause)
		begin
			next_st.paused = hwdata == PAUSE_CODE_SLEEP;
		end
		if (wr_startup)
		begin
			next_st.delay = hwdata[SU_DELAY_MSB:0];
			next_st.times_four = hwdata[SU_X4_BIT];
		end
		// Startup timer, cleared on the edge of a disable or pause write
		next_running = (next_st.enable_code != EN_CODE_DISABLE) & ~next_st.paused;
		if (!running || !next_running)
		begin
			next_st.timer = '0;
			next_st.stable = 1'b0;
		end
		else if (!st.stable && tick)
		begin
			if (timer_inc >= {1'b0, target})
			begin
				next_st.stable = 1'b1;
				irq_events[IRQ_STABLE] = 1'b1;
			end
			else
			begin
				next_st.timer = timer_inc[TIMER_W-1:0];
			end
		end
		// Invalid write flag, set wins over clear
		if (wr_status && hwdata[ST_BAD_BIT])
		begin
			next_st.bad_write = 1'b0;
		end
		if (bad_ctrl || bad_pause)
		begin
			next_st.bad_write = 1'b1;
			irq_events[IRQ_BADWR] = 1'b1;
		end
		// Crystal down counter
		if (wr_count)
		begin
			next_st.down_count = hwdata[CNT_W-1:0];
		end
		else if (tick && st.down_count != '0)
		begin
			next_st.down_count = st.down_count - 8'h01;
			if (st.down_count == 8'h01)
			begin
				irq_events[IRQ_CNTDONE] = 1'b1;
			end
		end
		// Interrupts: write one to clear, events win
		if (wr_irq_status)
		begin
			next_st.irq_status = st.irq_status & ~hwdata[IRQ_N-1:0];
		end
		next_st.irq_status = next_st.irq_status | irq_events;
		if (wr_irq_mask)
		begin
			next_st.irq_mask = hwdata[IRQ_N-1:0];
		end
		next_st.irq = |(next_st.irq_status & next_st.irq_mask);
		next_st.osc_enable = next_running;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= '0;
			st.hreadyout <= 1'b1;
			st.enable_code <= EN_CODE_DISABLE;
			st.paused <= 1'b0;
			st.delay <= SU_DELAY_RESET;
			st.times_four <= 1'b0;
			st.down_count <= CNT_RESET;
			st.irq_status <= IRQ_RESET;
			st.irq_mask <= IRQ_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign hrdata = st.hrdata;
	assign hreadyout = st.hreadyout;
	assign hresp = st.hresp;
	assign osc_enable = st.osc_enable;
	assign osc_stable = st.stable;
	assign irq = st.irq;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_status_read;
		take && !hwrite && haddr[7:2] == OFS_STATUS[7:2];
	endsequence
	sequence s_flags_shown;
		hrdata[ST_ENABLED_BIT] == $past(enabled) && hrdata[1:0] == 2'h0;
	endsequence
	sequence s_pin_wake;
		st.paused && st.wake_s2 && !wr_pause;
	endsequence

	property p_enable_off;
		wr_ctrl && hwdata[CTRL_EN_MSB:CTRL_EN_LSB] == EN_CODE_DISABLE |=> !osc_enable && !enabled;
	endproperty
	a_enable_off: assert property (p_enable_off) else $error("disable code left oscillator on");
	property p_enable_other;
		wr_ctrl && hwdata[CTRL_EN_MSB:CTRL_EN_LSB] != EN_CODE_DISABLE |=> enabled;
	endproperty
	a_enable_other: assert property (p_enable_other) else $error("non-disable code did not enable");
	property p_reset_off;
		$rose(hresetn) |-> !osc_enable && !osc_stable;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("oscillator on after reset");
	property p_range_fixed;
		st.dp_sel && !st.dp_write && st.dp_addr == OFS_CTRL[7:2] |-> hrdata[CTRL_FR_MSB:0] == FREQ_RANGE_RESET;
	endproperty
	a_range_fixed: assert property (p_range_fixed) else $error("range field not 0xAA0");
	property p_stable_running;
		osc_stable |-> running;
	endproperty
	a_stable_running: assert property (p_stable_running) else $error("stable while not running");
	property p_bad_write;
		bad_ctrl || bad_pause |=> st.bad_write && st.irq_status[IRQ_BADWR];
	endproperty
	a_bad_write: assert property (p_bad_write) else $error("invalid write not flagged");
	property p_flags_read;
		s_status_read |=> s_flags_shown;
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("status enabled or range bits wrong");
	property p_pause;
		wr_pause && hwdata == PAUSE_CODE_SLEEP |=> !osc_enable ##1 !osc_stable;
	endproperty
	a_pause: assert property (p_pause) else $error("pause code did not stop oscillator");
	property p_wake_code;
		wr_pause && hwdata != PAUSE_CODE_SLEEP |=> !st.paused;
	endproperty
	a_wake_code: assert property (p_wake_code) else $error("wake or invalid code left paused");
	property p_expiry;
		$rose(osc_stable) |-> $past(timer_inc) >= {1'b0, $past(target)} && $past(tick);
	endproperty
	a_expiry: assert property (p_expiry) else $error("stable set before delay elapsed");
	property p_count_down;
		tick && st.down_count != '0 && !wr_count |=> st.down_count == $past(st.down_count) - 8'h01;
	endproperty
	a_count_down: assert property (p_count_down) else $error("counter did not decrement");
	property p_count_hold;
		st.down_count == '0 && !wr_count |=> st.down_count == '0;
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("counter moved from zero");
	property p_count_load;
		wr_count |=> st.down_count == $past(hwdata[CNT_W-1:0]);
	endproperty
	a_count_load: assert property (p_count_load) else $error("counter not loaded");
	property p_pin_wake;
		s_pin_wake |=> !st.paused && !osc_stable;
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("wake pin did not restart");
	property p_restart;
		!running |=> st.timer == '0 && !osc_stable;
	endproperty
	a_restart: assert property (p_restart) else $error("timer not cleared when stopped");
	property p_enable_on;
		wr_ctrl && hwdata[CTRL_EN_MSB:CTRL_EN_LSB] == EN_CODE_ENABLE && !st.paused |=> osc_enable;
	endproperty
	a_enable_on: assert property (p_enable_on) else $error("enable code left oscillator off");
	property p_bad_clear;
		wr_status && hwdata[ST_BAD_BIT] |=> !st.bad_write;
	endproperty
	a_bad_clear: assert property (p_bad_clear) else $error("invalid write flag not cleared");
	property p_delay_wait;
		tick && running && !osc_stable && !st.times_four
			&& {1'b0, st.timer} + 25'h0000001 < {3'h0, st.delay, 8'h00} |=> !osc_stable;
	endproperty
	a_delay_wait: assert property (p_delay_wait) else $error("stable before the startup delay");
	property p_x4_wait;
		tick && running && !osc_stable && st.times_four
			&& {1'b0, st.timer} + 25'h0000001 < {1'b0, st.delay, 10'h000} |=> !osc_stable;
	endproperty
	a_x4_wait: assert property (p_x4_wait) else $error("stable before four times the delay");
	property p_disable_drop;
		wr_ctrl && hwdata[CTRL_EN_MSB:CTRL_EN_LSB] == EN_CODE_DISABLE |=> !osc_stable && st.timer == '0;
	endproperty
	a_disable_drop: assert property (p_disable_drop) else $error("stable kept after disable");
	property p_stable_irq;
		$rose(osc_stable) |-> st.irq_status[IRQ_STABLE];
	endproperty
	a_stable_irq: assert property (p_stable_irq) else $error("stable event not recorded");
	property p_count_irq;
		tick && st.down_count == 8'h01 && !wr_count |=> st.irq_status[IRQ_CNTDONE];
	endproperty
	a_count_irq: assert property (p_count_irq) else $error("counter end not recorded");
	property p_irq_level;
		irq == |(st.irq_status & st.irq_mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule : coc_crystal_osc_control
`default_nettype wire

// ### test/coc_crystal_osc_control_test.sv
/*
 Self-checking bench of the crystal oscillator control block: AHB-Lite master tasks, crystal tick source,
 read-data monitor fed from a queue of expected values.
 Assumes the block answers with no wait states and that hready is fed back from hreadyout.
*/
`timescale 1ns/1ns
`default_nettype none
module coc_crystal_osc_control_test;
	import coc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, xtal_clk_pin, wake_pin, rd_ph;
	logic [31:0] haddr, hwdata, hrdata, p;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hready, hreadyout, hresp, osc_enable, osc_stable, irq;
	logic [11:0] c;
	logic [31:0] exp_q[$];
	int error_cnt, checks, cyc;
	integer seed;
	localparam logic [31:0] st_bad = 32'h1 << ST_BAD_BIT;
	localparam logic [31:0] st_en = 32'h1 << ST_ENABLED_BIT;
	localparam logic [31:0] st_ok = 32'h1 << ST_STABLE_BIT;
	localparam int o_en = 0;
	localparam int o_ok = 1;
	localparam int o_irq = 2;
	assign hready = hreadyout;
	coc_crystal_osc_control DUT
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .xtal_clk_pin(xtal_clk_pin), .wake_pin(wake_pin), .osc_enable(osc_enable),
		.osc_stable(osc_stable), .irq(irq)
	);
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic chk_bit(input int sel, input logic exp);
		logic got;
		@(posedge hclk);
		@(negedge hclk);
		got = (sel == o_en) ? osc_enable : (sel == o_ok) ? osc_stable : irq;
		cmp({31'h0, got}, {31'h0, exp});
		@(posedge hclk);
	endtask : chk_bit
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic ticks(input int n);
		repeat (n)
		begin
			xtal_clk_pin <= 1'b1;
			repeat (2) @(posedge hclk);
			xtal_clk_pin <= 1'b0;
			repeat (2) @(posedge hclk);
		end
	endtask : ticks
	task automatic settle_stable(input int n);
		ticks(n - 1);
		chk_bit(o_ok, 1'b0);
		ticks(1);
		repeat (2) @(posedge hclk);
		chk_bit(o_ok, 1'b1);
	endtask : settle_stable
	always @(posedge hclk)
	begin
		if (rd_ph)
		begin
			cmp(hrdata, exp_q.pop_front());
			cmp({30'h0, hreadyout, hresp}, 32'h2);
		end
		rd_ph <= hsel && hready && htrans[1] && !hwrite;
	end
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	initial
	begin
		seed = 32'hf993;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		xtal_clk_pin = 1'b0;
		wake_pin = 1'b0;
		rd_ph = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_bit(o_en, 1'b0);
		rd(OFS_CTRL, {8'h00, EN_CODE_DISABLE, FREQ_RANGE_RESET});
		rd(OFS_STATUS, 32'h0);
		rd(OFS_PAUSE, PAUSE_CODE_WAKE);
		rd(OFS_STARTUP, {18'h0, SU_DELAY_RESET});
		rd(OFS_COUNT, 32'h0);
		rd(8'h10, 32'h0);
		repeat (3)
		begin
			c = 12'($random(seed));
			if (c == EN_CODE_DISABLE || c == EN_CODE_ENABLE)
				c = c ^ 12'h001;
			wr(OFS_CTRL, {8'h00, c, FREQ_RANGE_RESET});
			rd(OFS_CTRL, {8'h00, c, FREQ_RANGE_RESET});
			rd(OFS_STATUS, st_bad | st_en);
			wr(OFS_STATUS, st_bad);
			rd(OFS_STATUS, st_en);
		end
		wr(OFS_CTRL, {8'h00, EN_CODE_DISABLE, 12'hAA1});
		rd(OFS_CTRL, {8'h00, EN_CODE_DISABLE, FREQ_RANGE_RESET});
		rd(OFS_STATUS, st_bad);
		wr(OFS_STATUS, st_bad);
		wr(OFS_STARTUP, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h7);
		wr(OFS_IRQ_MASK, 32'h0);
		wr(OFS_CTRL, {8'h00, EN_CODE_ENABLE, FREQ_RANGE_RESET});
		chk_bit(o_en, 1'b1);
		settle_stable(256);
		rd(OFS_STATUS, st_ok | st_en);
		rd(OFS_IRQ_STATUS, 32'h1);
		chk_bit(o_irq, 1'b0);
		wr(OFS_IRQ_MASK, 32'h1);
		rd(OFS_IRQ_MASK, 32'h1);
		chk_bit(o_irq, 1'b1);
		wr(OFS_IRQ_STATUS, 32'h1);
		chk_bit(o_irq, 1'b0);
		wr(OFS_CTRL, {8'h00, EN_CODE_DISABLE, FREQ_RANGE_RESET});
		chk_bit(o_ok, 1'b0);
		wr(OFS_STARTUP, 32'h0010_0001);
		rd(OFS_STARTUP, 32'h0010_0001);
		wr(OFS_CTRL, {8'h00, EN_CODE_ENABLE, FREQ_RANGE_RESET});
		settle_stable(1024);
		wr(OFS_PAUSE, PAUSE_CODE_SLEEP);
		chk_bit(o_en, 1'b0);
		chk_bit(o_ok, 1'b0);
		rd(OFS_PAUSE, PAUSE_CODE_SLEEP);
		wake_pin <= 1'b1;
		repeat (4) @(posedge hclk);
		wake_pin <= 1'b0;
		repeat (2) @(posedge hclk);
		chk_bit(o_en, 1'b1);
		rd(OFS_PAUSE, PAUSE_CODE_WAKE);
		settle_stable(1024);
		wr(OFS_PAUSE, PAUSE_CODE_SLEEP);
		p = $random(seed);
		if (p == PAUSE_CODE_SLEEP || p == PAUSE_CODE_WAKE)
			p = p ^ 32'h1;
		wr(OFS_PAUSE, p);
		rd(OFS_PAUSE, PAUSE_CODE_WAKE);
		rd(OFS_STATUS, st_bad | st_en);
		wr(OFS_IRQ_MASK, 32'h4);
		wr(OFS_IRQ_STATUS, 32'h7);
		wr(OFS_COUNT, 32'h5);
		ticks(3);
		rd(OFS_COUNT, 32'h2);
		chk_bit(o_irq, 1'b0);
		ticks(5);
		rd(OFS_COUNT, 32'h0);
		rd(OFS_IRQ_STATUS, 32'h4);
		chk_bit(o_irq, 1'b1);
		wrap_up();
	end
endmodule : coc_crystal_osc_control_test
`default_nettype wire
